/* rtl/pbg_port.sv */
`timescale 1ns/10ps
// How it works
// - Per-pin change enables, cleared at reset
// - Weak pull-up enable bits on pins 1 and 4-7
// - Pull-up off whenever pin is output
// - Global pull-up control resets to disabled
// - Pull-up needs global, input, enable, digital
// - Analog-selected pins read as zero
// - Analog select leaves digital output working
// - Direction drives output even on analog pins
// - Analog select resets set; software clears
// - Pin zero is open-drain, low only
// - Highest enabled output function owns pin
// - Alternate function beats port latch
// - Outputs may drive pins in analog mode
// - Data bits 3-2 read zero
// - Direction one is input, resets to one
// - Read gives pins, write sets latch
`include "pbg_map.svh"
module pbg_port #(
    parameter bit WIDE_VARIANT = 1'b1
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic [3:0]       reg_addr,
    input  wire pbg_pkg::pbg_byte_t reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output pbg_pkg::pbg_byte_t    reg_rdata,
    input  wire pbg_pkg::pbg_byte_t pin_in,
    output pbg_pkg::pbg_byte_t    pin_out,
    output pbg_pkg::pbg_byte_t    pin_oe,
    output pbg_pkg::pbg_byte_t    pin_pullup,
    input  wire pbg_pkg::pbg_byte_t alt_en,
    input  wire pbg_pkg::pbg_byte_t alt_out,
    output pbg_pkg::pbg_byte_t    pin_change
);
    import pbg_pkg::*;

    localparam pbg_byte_t IMPL = WIDE_VARIANT ? `PBG_MASK_WIDE : `PBG_MASK_NARROW;
    localparam pbg_byte_t ALT  = `PBG_MASK_ALT;

    pbg_state_t s_q;
    pbg_state_t s_d;
    pbg_byte_t  out_w;
    pbg_byte_t  oe_w;
    pbg_byte_t  pu_w;
    pbg_byte_t  rd_w;
    pbg_byte_t  chg_w;

    // One slice per pin; pin zero is the open-drain one
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            pbg_pin #(
                .OPEN_DRAIN (gi == `PBG_BIT_OD_PIN)
            ) u_pin (
                .dir      (s_q.dir[gi]),
                .latch    (s_q.latch[gi]),
                .pu_en    (s_q.pu_en[gi]),
                .analog   (s_q.analog[gi]),
                .chg_en   (s_q.chg_en[gi]),
                .pu_allow (~s_q.gpu_dis),
                // only pins with an alternate owner take it
                .alt_en   (alt_en[gi] & ALT[gi]),
                .alt_val  (alt_out[gi]),
                .sync_lvl (s_q.sync2[gi]),
                .prev_lvl (s_q.prev[gi]),
                .out_d    (out_w[gi]),
                .oe_d     (oe_w[gi]),
                .pu_d     (pu_w[gi]),
                .rd       (rd_w[gi]),
                .chg      (chg_w[gi])
            );
        end
    endgenerate

    // Next-state logic: register writes, synchroniser, pin outputs, readback
    always_comb begin
        s_d = s_q;
        // Two-stage sync; stage one feeds stage two only
        s_d.sync1 = pin_in;
        s_d.sync2 = s_q.sync1;
        s_d.prev  = s_q.sync2;
        // one-cycle change pulse per enabled pin
        s_d.chg = chg_w & IMPL;
        s_d.pin_out = out_w & IMPL;
        // oe not gated by analog mode
        s_d.pin_oe  = oe_w & IMPL;
        // pull-up drops when pin is output
        s_d.pin_pu  = pu_w & IMPL & `PBG_MASK_PULLUP;
        s_d.rdata   = 8'h00;
        if (reg_wr) begin
            unique case (reg_addr)
                // write lands in the output latch
                `PBG_OFF_DATA:   s_d.latch   = reg_wdata & IMPL;
                // direction write, unimplemented bits stay zero
                `PBG_OFF_DIR:    s_d.dir     = reg_wdata & IMPL;
                `PBG_OFF_PULLUP: s_d.pu_en   = reg_wdata & IMPL & `PBG_MASK_PULLUP;
                // software clears analog select to go digital
                `PBG_OFF_ANALOG: s_d.analog  = reg_wdata & IMPL & `PBG_MASK_ANALOG;
                `PBG_OFF_CHG_EN: s_d.chg_en  = reg_wdata & `PBG_MASK_CHG_EN;
                `PBG_OFF_OPTION: s_d.gpu_dis = reg_wdata[`PBG_BIT_GPU_DIS];
                default:         s_d.latch   = s_q.latch; // Unmapped write ignored
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                // pin levels, bits 3-2 forced zero
                `PBG_OFF_DATA:   s_d.rdata = rd_w & IMPL;
                `PBG_OFF_DIR:    s_d.rdata = s_q.dir;
                `PBG_OFF_PULLUP: s_d.rdata = s_q.pu_en;
                `PBG_OFF_ANALOG: s_d.rdata = s_q.analog;
                `PBG_OFF_CHG_EN: s_d.rdata = s_q.chg_en;
                `PBG_OFF_OPTION: s_d.rdata = {s_q.gpu_dis, 7'h00};
                default:         s_d.rdata = 8'h00; // Unmapped reads zero
            endcase
        end
    end

    // State register; latch value is undefined on the part, zero here
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q         <= '0;
            s_q.latch   <= `PBG_RST_LATCH;
            s_q.dir     <= IMPL & `PBG_RST_DIR;
            s_q.pu_en   <= IMPL & `PBG_RST_PULLUP;
            s_q.analog  <= IMPL & `PBG_RST_ANALOG;
            s_q.chg_en  <= `PBG_RST_CHG_EN;
            s_q.gpu_dis <= `PBG_RST_GPU_DIS;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata  = s_q.rdata;
    assign pin_out    = s_q.pin_out;
    assign pin_oe     = s_q.pin_oe;
    assign pin_pullup = s_q.pin_pu;
    assign pin_change = s_q.chg;

    // Checks on the port behaviour
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    AST_CHG_NEEDS_EN: assert property (
        (pin_change & ~$past(s_q.chg_en)) == 8'h00)
        else $error("change event on a pin without its enable");

    AST_PU_OFF_OUTPUT: assert property (
        (pin_pullup & ~$past(s_q.dir)) == 8'h00)
        else $error("pull-up active on an output pin");

    AST_PU_GLOBAL_OFF: assert property (
        $past(s_q.gpu_dis) |-> pin_pullup == 8'h00)
        else $error("pull-up active while globally disabled");

    AST_ANALOG_READS_ZERO: assert property (
        (reg_rd && reg_addr == `PBG_OFF_DATA) |=> (reg_rdata & $past(s_q.analog)) == 8'h00)
        else $error("analog pin read back nonzero");

    AST_PIN0_OPEN_DRAIN: assert property (
        pin_out[0] == 1'b0)
        else $error("pin zero driven high");

    AST_ALT_PRIORITY: assert property (
        (alt_en[7] && !s_q.dir[7] && WIDE_VARIANT) |=> pin_out[7] == $past(alt_out[7]))
        else $error("alternate function lost priority on pin seven");

    AST_DRIVE_ON_ANALOG: assert property (
        (!s_q.dir[1] && s_q.analog[1]) |=> pin_oe[1])
        else $error("driver off on analog output pin");

    AST_UNIMPL_ZERO: assert property (
        (reg_rd && reg_addr == `PBG_OFF_DATA) |=> reg_rdata[3:2] == 2'h0)
        else $error("unimplemented data bits read nonzero");

    AST_DIR_WRITE: assert property (
        (reg_wr && reg_addr == `PBG_OFF_DIR) |=> s_q.dir == ($past(reg_wdata) & IMPL))
        else $error("direction write not stored");

    AST_READ_PIN_LEVEL: assert property (
        (reg_rd && reg_addr == `PBG_OFF_DATA)
        |=> reg_rdata == ($past(s_q.sync2) & ~$past(s_q.analog) & IMPL))
        else $error("data read does not show pin level");

    // Unimplemented pins must stay dead on every output, or a board net floats into a drive
    AST_OE_UNIMPL: assert property (
        (pin_oe & ~IMPL) == 8'h00)
        else $error("driver enabled on an unimplemented pin");

    AST_OUT_UNIMPL: assert property (
        (pin_out & ~IMPL) == 8'h00)
        else $error("drive value on an unimplemented pin");

    AST_PU_UNIMPL: assert property (
        (pin_pullup & ~(IMPL & `PBG_MASK_PULLUP)) == 8'h00)
        else $error("pull-up on a pin without an enable bit");

    AST_CHG_UNIMPL: assert property (
        (pin_change & ~IMPL) == 8'h00)
        else $error("change event on an unimplemented pin");

    // Pull-up gating, one condition at a time
    AST_PU_ANALOG_OFF: assert property (
        (pin_pullup & $past(s_q.analog)) == 8'h00)
        else $error("pull-up active on an analog pin");

    AST_PU_NEEDS_EN: assert property (
        (pin_pullup & ~$past(s_q.pu_en)) == 8'h00)
        else $error("pull-up active without its enable");

    AST_PU_ON: assert property (
        (!s_q.gpu_dis && s_q.dir[1] && s_q.pu_en[1] && !s_q.analog[1]) |=> pin_pullup[1])
        else $error("pull-up missing on an enabled input pin");

    AST_CHG_ANALOG_OFF: assert property (
        (pin_change & $past(s_q.analog)) == 8'h00)
        else $error("change event on an analog pin");

    AST_CHG_DETECT: assert property (
        (s_q.chg_en[1] && !s_q.analog[1] && (s_q.sync2[1] != s_q.prev[1])) |=> pin_change[1])
        else $error("level change on pin one not reported");

    // Open drain: driver on only while the wanted level is low
    AST_PIN0_OE_NEEDS_DIR: assert property (
        pin_oe[0] |-> !$past(s_q.dir[0]))
        else $error("pin zero driven while an input");

    AST_PIN0_ALT_LOW: assert property (
        (alt_en[0] && !alt_out[0] && !s_q.dir[0]) |=> pin_oe[0])
        else $error("pin zero not pulled low by its alternate owner");

    AST_OE_FOLLOWS_DIR: assert property (
        (pin_oe & IMPL & 8'hfe) == (~$past(s_q.dir) & IMPL & 8'hfe))
        else $error("driver enable does not follow direction");

    // Priority mux, pin by pin; pin five has no alternate owner
    AST_ALT_PIN1: assert property (
        (alt_en[1] && !s_q.dir[1]) |=> pin_out[1] == $past(alt_out[1]))
        else $error("alternate function lost priority on pin one");

    AST_ALT_PIN4: assert property (
        (alt_en[4] && !s_q.dir[4] && WIDE_VARIANT) |=> pin_out[4] == $past(alt_out[4]))
        else $error("alternate function lost priority on pin four");

    AST_LATCH_PIN5: assert property (
        (!s_q.dir[5] && WIDE_VARIANT) |=> pin_out[5] == $past(s_q.latch[5]))
        else $error("pin five not driven from its latch");

    AST_ANALOG_OUT_KEEPS: assert property (
        (!s_q.dir[1] && s_q.analog[1] && !alt_en[1]) |=> pin_out[1] == $past(s_q.latch[1]))
        else $error("analog select changed the digital output");

    // Register writes land one edge after the strobe
    AST_LATCH_WRITE: assert property (
        (reg_wr && reg_addr == `PBG_OFF_DATA) |=> s_q.latch == ($past(reg_wdata) & IMPL))
        else $error("data write not stored in the latch");

    AST_PU_WRITE: assert property (
        (reg_wr && reg_addr == `PBG_OFF_PULLUP)
        |=> s_q.pu_en == ($past(reg_wdata) & IMPL & `PBG_MASK_PULLUP))
        else $error("pull-up enable write not stored");

    AST_ANALOG_WRITE: assert property (
        (reg_wr && reg_addr == `PBG_OFF_ANALOG)
        |=> s_q.analog == ($past(reg_wdata) & IMPL & `PBG_MASK_ANALOG))
        else $error("analog select write not stored");

    AST_CHG_EN_WRITE: assert property (
        (reg_wr && reg_addr == `PBG_OFF_CHG_EN)
        |=> s_q.chg_en == ($past(reg_wdata) & `PBG_MASK_CHG_EN))
        else $error("change enable write not stored");

    AST_OPTION_WRITE: assert property (
        (reg_wr && reg_addr == `PBG_OFF_OPTION) |=> s_q.gpu_dis == $past(reg_wdata[7]))
        else $error("global pull-up control write not stored");

    // Read data stands one cycle only, so a late sampler sees zero, not stale data
    AST_RDATA_IDLE: assert property (
        !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data present without a read");

    AST_UNMAPPED_READ: assert property (
        (reg_rd && reg_addr > `PBG_OFF_OPTION) |=> reg_rdata == 8'h00)
        else $error("unmapped read returned data");

    AST_RD_DIR: assert property (
        (reg_rd && reg_addr == `PBG_OFF_DIR) |=> reg_rdata == $past(s_q.dir))
        else $error("direction read does not match stored value");

    AST_RD_ANALOG: assert property (
        (reg_rd && reg_addr == `PBG_OFF_ANALOG) |=> reg_rdata == $past(s_q.analog))
        else $error("analog select read does not match stored value");

    AST_RD_CHG_EN: assert property (
        (reg_rd && reg_addr == `PBG_OFF_CHG_EN) |=> reg_rdata == $past(s_q.chg_en))
        else $error("change enable read does not match stored value");

endmodule

/* rtl/pbg_map.svh */
`ifndef PBG_MAP_SVH
`define PBG_MAP_SVH

// Register offsets on the local register port (index = address)
`define PBG_OFF_DATA      4'h0
`define PBG_OFF_DIR       4'h1
`define PBG_OFF_PULLUP    4'h2
`define PBG_OFF_ANALOG    4'h3
`define PBG_OFF_CHG_EN    4'h4
`define PBG_OFF_OPTION    4'h5

// Implemented-bit masks
`define PBG_MASK_WIDE     8'hf3
`define PBG_MASK_NARROW   8'h03
`define PBG_MASK_PULLUP   8'hf2
`define PBG_MASK_ANALOG   8'h72
`define PBG_MASK_CHG_EN   8'hf7
`define PBG_MASK_OPTION   8'h80

// Pins that own an alternate output function
`define PBG_MASK_ALT      8'h93

// Field positions
`define PBG_BIT_GPU_DIS   7
`define PBG_BIT_OD_PIN    0

// Reset values
`define PBG_RST_LATCH     8'h00
`define PBG_RST_DIR       8'hf3
`define PBG_RST_PULLUP    8'hf2
`define PBG_RST_ANALOG    8'h72
`define PBG_RST_CHG_EN    8'h00
`define PBG_RST_GPU_DIS   1'b1

`endif

/* rtl/pbg_pkg.sv */
package pbg_pkg;

    typedef logic [7:0] pbg_byte_t;

    // Complete state of the port
    typedef struct packed {
        pbg_byte_t latch;
        pbg_byte_t dir;
        pbg_byte_t pu_en;
        pbg_byte_t analog;
        pbg_byte_t chg_en;
        logic      gpu_dis;
        pbg_byte_t sync1;
        pbg_byte_t sync2;
        pbg_byte_t prev;
        pbg_byte_t rdata;
        pbg_byte_t pin_out;
        pbg_byte_t pin_oe;
        pbg_byte_t pin_pu;
        pbg_byte_t chg;
    } pbg_state_t;

endpackage

/* rtl/pbg_pin.sv */
`timescale 1ns/10ps
// Per-pin combinational slice: output mux, pull-up gate, read path, change detect
module pbg_pin #(
    parameter bit OPEN_DRAIN = 1'b0
) (
    input  wire logic dir,
    input  wire logic latch,
    input  wire logic pu_en,
    input  wire logic analog,
    input  wire logic chg_en,
    input  wire logic pu_allow,
    input  wire logic alt_en,
    input  wire logic alt_val,
    input  wire logic sync_lvl,
    input  wire logic prev_lvl,
    output logic      out_d,
    output logic      oe_d,
    output logic      pu_d,
    output logic      rd,
    output logic      chg
);
    logic drv_val;

    always_comb begin
        drv_val = alt_en ? alt_val : latch;
        if (OPEN_DRAIN) begin
            out_d = 1'b0;
            oe_d  = ~dir & ~drv_val;
        end else begin
            out_d = drv_val;
            // driver follows direction even if analog
            oe_d  = ~dir;
        end
        pu_d = pu_allow & dir & pu_en & ~analog;
        rd   = ~analog & sync_lvl;
        chg  = chg_en & ~analog & (sync_lvl ^ prev_lvl);
    end

endmodule

/* verif/pbg_board.sv */
`timescale 1ns/10ps
// Board side: external drivers, pull-ups, floating lines
module pbg_board (
    input  wire logic         clk,
    input  pbg_pkg::pbg_byte_t pin_out,
    input  pbg_pkg::pbg_byte_t pin_oe,
    input  pbg_pkg::pbg_byte_t pin_pullup,
    input  pbg_pkg::pbg_byte_t ext_val,
    input  pbg_pkg::pbg_byte_t ext_en,
    output pbg_pkg::pbg_byte_t pin_in
);
    import pbg_pkg::*;
    pbg_byte_t float_q = 8'h5a;
    // Undriven line wanders, so a stale level never looks valid
    always_ff @(posedge clk) begin
        float_q <= ~float_q;
    end
    // Device driver wins, then board driver, then pull-up
    // pin zero relies on a board pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                        (pin_pullup[i] || i == 0) ? 1'b1 : float_q[i];
        end
    end
endmodule

/* verif/test_port_b_gpio_pin_logic.sv */
`timescale 1ns/10ps
module test_port_b_gpio_pin_logic;
    import pbg_pkg::*;
    logic       clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0;
    logic [3:0] reg_addr = '0;
    pbg_byte_t  reg_wdata = '0, alt_en = '0, alt_out = '0, ext_val = '0, ext_en = '0;
    pbg_byte_t  reg_rdata, pin_in, pin_out, pin_oe, pin_pullup, pin_change;
    pbg_byte_t  rv[6], w, rd_v, lvl, m, d;
    pbg_byte_t  msk[6] = '{8'hf3, 8'hf3, 8'hf2, 8'h72, 8'hf7, 8'h80};
    pbg_byte_t  rst[6] = '{8'h00, 8'hf3, 8'hf2, 8'h72, 8'h00, 8'h80};
    int         miscompares = 0, cmp_count = 0;

    always #4 clk = ~clk;

    pbg_port i_dut (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup), .alt_en(alt_en),
        .alt_out(alt_out), .pin_change(pin_change));
    pbg_board i_board (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pullup(pin_pullup), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));

    task automatic chk(input string nm, input pbg_byte_t e, input pbg_byte_t g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input pbg_byte_t v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output pbg_byte_t v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    // Alternate function overrides the latch on pins 0,1,4,7
    function automatic pbg_byte_t e_val();
        return (alt_en & 8'h93 & alt_out) | (~(alt_en & 8'h93) & rv[0]);
    endfunction
    // Pin zero only ever pulls low
    function automatic pbg_byte_t e_oe();
        return ~rv[1] & 8'hf3 & ~(e_val() & 8'h01);
    endfunction
    function automatic pbg_byte_t e_pu();
        return rv[5][7] ? 8'h00 : rv[1] & rv[2] & ~rv[3];
    endfunction

    task automatic end_sim();
        if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    initial begin
        void'($urandom(41741));
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        for (int a = 1; a < 6; a++) begin
            rd(a[3:0], rd_v);
            chk("reset reg", rst[a], rd_v);
        end
        chk("reset pullup", 8'h00, pin_pullup);
        rv = rst;
        for (int it = 0; it < 40; it++) begin
            for (int a = 0; a < 6; a++) begin
                w = pbg_byte_t'($urandom);
                // early rounds keep analog pins as inputs
                if (a == 3 && it < 20) w = w & rv[1];
                wr(a[3:0], w);
                rv[a] = w & msk[a];
            end
            alt_en <= pbg_byte_t'($urandom);
            alt_out <= pbg_byte_t'($urandom);
            ext_en <= pbg_byte_t'($urandom);
            ext_val <= pbg_byte_t'($urandom);
            repeat (6) @(posedge clk);
            #1;
            chk("pin_oe", e_oe(), pin_oe);
            chk("pin_out", e_val() & e_oe() & 8'hf2, pin_out & e_oe());
            chk("pin_out spare", 8'h00, pin_out & 8'h0d);
            chk("pin_pullup", e_pu(), pin_pullup);
            lvl = (e_oe() & e_val()) | (~e_oe() & ext_en & ext_val) | (~e_oe() & ~ext_en);
            // Floating pins carry no defined level
            m = e_oe() | ext_en | e_pu() | rv[3] | 8'h0d;
            rd(4'h0, rd_v);
            chk("pin data", lvl & ~rv[3] & 8'hf3 & m, rd_v & m);
            for (int a = 1; a < 7; a++) begin
                rd(a[3:0], rd_v);
                chk("reg", (a < 6) ? rv[a] : 8'h00, rd_v);
            end
            d = pbg_byte_t'($urandom);
            @(posedge clk);
            ext_val <= ext_val ^ d;
            repeat (3) @(posedge clk);
            #1;
            chk("pin_change", d & ext_en & ~e_oe() & rv[4] & ~rv[3] & 8'hf3 & m,
                pin_change & m);
            @(posedge clk);
            #1;
            chk("pin_change end", 8'h00, pin_change & m);
        end
        end_sim();
    end
endmodule
